// File: ipf_top.sv
// Input pulse filter and analog averaging filter with an APB register file.
`timescale 1ns/100ps
`default_nettype none

module ipf_top #(
	parameter int N_ANA      = 8,
	parameter int CYC_PER_MS = ipf_pkg::MS_CYC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire ipf_pkg::ipf_apb_req_t apb,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [29:0]           pin_raw,
	input  wire logic                  scan_tick,
	input  wire logic [7:0][11:0]      ana_raw,
	output logic [29:0]                din_img
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic int ana_pin(input int nch, input int ch);
		case (nch)
			2:       ana_pin = 6 + ch;
			4:       ana_pin = 12 + ch;
			6:       ana_pin = 18 + ch;
			default: ana_pin = (ch < 2) ? 22 + ch : 22 + ch;
		endcase
	endfunction

	function automatic logic [9:0] scale(input logic [11:0] raw);
		logic [22:0] p;
		p = 23'(raw) * 23'(ipf_pkg::SCALE_MUL);
		scale = p[21:12];
	endfunction

	function automatic logic [3:0] clamp_flt(input logic [3:0] v);
		clamp_flt = (v != 4'h0 && v < ipf_pkg::FLT_MIN_MS) ? ipf_pkg::FLT_MIN_MS : v;
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && (a <= ipf_pkg::ADDR_IMG ||
			(a >= ipf_pkg::ADDR_RES0 && a <= ipf_pkg::ADDR_RES7));
	endfunction

	// ****************************************
	// Configuration: shadow written by software, active copy on load
	// ****************************************
	ipf_pkg::ipf_cfg_t sh_q;
	ipf_pkg::ipf_cfg_t act_q;
	logic              load_q;
	logic              acc;
	logic              wr;

	assign acc = apb.psel && apb.penable;
	assign wr  = acc && pready && apb.pwrite && addr_ok(apb.paddr);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sh_q <= ipf_pkg::CFG_RST;
		end else if (wr) begin
			case (apb.paddr)
				ipf_pkg::ADDR_FLT:    sh_q.flt <= apb.pwdata[15:0];
				ipf_pkg::ADDR_AEN:    sh_q.aen <= apb.pwdata[7:0];
				ipf_pkg::ADDR_CNT_LO: sh_q.cnt[3:0] <= apb.pwdata;
				ipf_pkg::ADDR_CNT_HI: sh_q.cnt[7:4] <= apb.pwdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			load_q <= 1'b0;
		end else begin
			load_q <= wr && apb.paddr == ipf_pkg::ADDR_LOAD && apb.pwdata[0];
		end
	end

	// Settings only act after a load, so a half-written set never steers the filters.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			act_q <= ipf_pkg::CFG_RST;
		end else if (load_q) begin
			act_q.aen <= sh_q.aen;
			act_q.cnt <= sh_q.cnt;
			for (int g = 0; g < ipf_pkg::N_GRP; g++) begin
				act_q.flt[g] <= clamp_flt(sh_q.flt[g]);
			end
		end
	end

	// ****************************************
	// Millisecond time base
	// ****************************************
	logic [19:0] ms_cnt_q;
	logic        ms_tick_q;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ms_cnt_q  <= 20'h0;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= ms_cnt_q == 20'(CYC_PER_MS - 1);
			ms_cnt_q  <= (ms_cnt_q == 20'(CYC_PER_MS - 1)) ? 20'h0 : ms_cnt_q + 20'h1;
		end
	end

	// ****************************************
	// Digital pulse filter
	// ****************************************
	logic [29:0] s1_q;
	logic [29:0] s2_q;
	logic [29:0] filt;
	logic [29:0] ana_mask;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s1_q <= 30'h0;
			s2_q <= 30'h0;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
		end
	end

	// A change is taken after set-1 whole ms ticks of stability: since tick phase is free,
	// a pulse below set-2 ms never sees that many ticks and one of set ms always does.
	for (genvar i = 0; i < ipf_pkg::N_PIN; i++) begin : g_pin
		logic [3:0] set;
		logic [3:0] cnt_q;
		logic       lvl_q;
		if (i < ipf_pkg::N_LOW) begin : g_low
			assign set = act_q.flt[i / 2];
		end else begin : g_fix
			assign set = ipf_pkg::FLT_FIX_MS;
		end
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				cnt_q <= 4'h0;
				lvl_q <= 1'b0;
			end else if (set == 4'h0 || s2_q[i] == lvl_q) begin
				cnt_q <= 4'h0;
				lvl_q <= s2_q[i];
			end else if (ms_tick_q) begin
				if (cnt_q + 4'h1 >= set - ipf_pkg::FLT_GUARD) begin
					cnt_q <= 4'h0;
					lvl_q <= s2_q[i];
				end else begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
		assign filt[i] = lvl_q;
	end

	always_comb begin
		ana_mask = 30'h0;
		for (int c = 0; c < N_ANA; c++) begin
			ana_mask[ana_pin(N_ANA, c)] = act_q.aen[c];
		end
	end

	// The image is taken at the scan edge, so a pulse needs its filter time plus a scan.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			din_img <= 30'h0;
		end else if (scan_tick) begin
			din_img <= filt & ~ana_mask;
		end
	end

	// ****************************************
	// Analog averaging, one channel at a time after each scan
	// ****************************************
	ipf_pkg::ipf_avg_st_t st_q;
	logic [9:0]  win_mem [0:2047];
	logic [7:0][9:0]  samp_q;
	logic [7:0][9:0]  res_q;
	logic [17:0] sum_q [8];
	logic [7:0]  ptr_q [8];
	logic [7:0]  fill_q [8];
	logic [2:0]  ch_q;
	logic [9:0]  old_q;
	logic [17:0] quo_q;
	logic [8:0]  rem_q;
	logic [7:0]  dvs_q;
	logic [4:0]  step_q;
	logic [8:0]  trial;
	logic [7:0]  n;
	logic        full;
	logic [17:0] sum_new;

	assign n       = act_q.cnt[ch_q];
	assign full    = fill_q[ch_q] == n;
	assign sum_new = sum_q[ch_q] + 18'(samp_q[ch_q]) - (full ? 18'(old_q) : 18'h0);
	assign trial   = {rem_q[7:0], quo_q[17]};

	always_ff @(posedge ref_clk) begin
		if (st_q == ipf_pkg::ST_UPD && n != 8'h0) begin
			win_mem[{ch_q, ptr_q[ch_q]}] <= samp_q[ch_q];
		end
		old_q <= win_mem[{ch_q, ptr_q[ch_q]}];
	end

	// A scan tick that lands while channels are still being worked is dropped;
	// the walk takes under 200 cycles, far below any scan period.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_q   <= ipf_pkg::ST_IDLE;
			ch_q   <= 3'h0;
			samp_q <= '0;
			quo_q  <= 18'h0;
			rem_q  <= 9'h0;
			dvs_q  <= 8'h0;
			step_q <= 5'h0;
		end else if (load_q) begin
			st_q <= ipf_pkg::ST_IDLE;
		end else begin
			case (st_q)
				ipf_pkg::ST_IDLE: begin
					ch_q <= 3'h0;
					if (scan_tick) begin
						for (int c = 0; c < ipf_pkg::N_CH; c++) begin
							samp_q[c] <= scale(ana_raw[c]);
						end
						st_q <= ipf_pkg::ST_RD;
					end
				end
				ipf_pkg::ST_RD: st_q <= ipf_pkg::ST_UPD;
				ipf_pkg::ST_UPD: begin
					rem_q  <= 9'h0;
					step_q <= 5'h0;
					if (n == 8'h0) begin
						quo_q <= 18'(samp_q[ch_q]);
						st_q  <= ipf_pkg::ST_STORE;
					end else begin
						quo_q <= sum_new;
						dvs_q <= full ? n : fill_q[ch_q] + 8'h1;
						st_q  <= ipf_pkg::ST_DIV;
					end
				end
				ipf_pkg::ST_DIV: begin
					if (trial >= {1'b0, dvs_q}) begin
						rem_q <= trial - {1'b0, dvs_q};
						quo_q <= {quo_q[16:0], 1'b1};
					end else begin
						rem_q <= trial;
						quo_q <= {quo_q[16:0], 1'b0};
					end
					step_q <= step_q + 5'h1;
					if (step_q == 5'(ipf_pkg::DIV_STEPS - 1)) begin
						st_q <= ipf_pkg::ST_STORE;
					end
				end
				ipf_pkg::ST_STORE: begin
					ch_q <= ch_q + 3'h1;
					st_q <= (ch_q == 3'h7) ? ipf_pkg::ST_IDLE : ipf_pkg::ST_RD;
				end
				default: st_q <= ipf_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int c = 0; c < ipf_pkg::N_CH; c++) begin
				sum_q[c]  <= 18'h0;
				ptr_q[c]  <= 8'h0;
				fill_q[c] <= 8'h0;
			end
		end else if (load_q) begin
			for (int c = 0; c < ipf_pkg::N_CH; c++) begin
				sum_q[c]  <= 18'h0;
				ptr_q[c]  <= 8'h0;
				fill_q[c] <= 8'h0;
			end
		end else if (st_q == ipf_pkg::ST_UPD && n != 8'h0) begin
			sum_q[ch_q]  <= sum_new;
			fill_q[ch_q] <= full ? fill_q[ch_q] : fill_q[ch_q] + 8'h1;
			ptr_q[ch_q]  <= (ptr_q[ch_q] + 8'h1 == n) ? 8'h0 : ptr_q[ch_q] + 8'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			res_q <= '0;
		end else if (load_q) begin
			res_q <= '0;
		end else if (st_q == ipf_pkg::ST_STORE) begin
			res_q[ch_q] <= (32'(ch_q) < N_ANA && act_q.aen[ch_q]) ? quo_q[9:0] : 10'h0;
		end
	end

	// ****************************************
	// APB slave: one wait state, then pready
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !addr_ok(apb.paddr);
			prdata  <= 32'h0;
			if (acc && !pready && !apb.pwrite) begin
				case (apb.paddr)
					ipf_pkg::ADDR_FLT:    prdata <= {16'h0, sh_q.flt};
					ipf_pkg::ADDR_AEN:    prdata <= {24'h0, sh_q.aen};
					ipf_pkg::ADDR_CNT_LO: prdata <= sh_q.cnt[3:0];
					ipf_pkg::ADDR_CNT_HI: prdata <= sh_q.cnt[7:4];
					ipf_pkg::ADDR_IMG:    prdata <= {2'h0, din_img};
					default: begin
						if (addr_ok(apb.paddr) && apb.paddr >= ipf_pkg::ADDR_RES0) begin
							prdata <= {22'h0, res_q[apb.paddr[4:2]]};
						end
					end
				endcase
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_load_flt;
		@(posedge ref_clk) disable iff (rst)
		load_q |=> act_q.flt[0] == clamp_flt($past(sh_q.flt[0]));
	endproperty
	a_load_flt: assert property (p_load_flt) else $error("group filter not taken on load");

	property p_flt_legal;
		@(posedge ref_clk) disable iff (rst)
		act_q.flt[1] == 4'h0 || act_q.flt[1] >= ipf_pkg::FLT_MIN_MS;
	endproperty
	a_flt_legal: assert property (p_flt_legal) else $error("illegal filter setting active");

	property p_fix_slow;
		@(posedge ref_clk) disable iff (rst)
		$changed(filt[9]) |-> $past(ms_tick_q, 1);
	endproperty
	a_fix_slow: assert property (p_fix_slow) else $error("fixed filter changed off a tick");

	property p_raw_pass;
		@(posedge ref_clk) disable iff (rst)
		act_q.flt[0] == 4'h0 && $stable(act_q.flt[0]) |-> filt[0] == $past(s2_q[0]);
	endproperty
	a_raw_pass: assert property (p_raw_pass) else $error("zero setting did not pass input");

	property p_img_scan;
		@(posedge ref_clk) disable iff (rst)
		$changed(din_img) |-> $past(scan_tick);
	endproperty
	a_img_scan: assert property (p_img_scan) else $error("image changed outside a scan");

	property p_ana_off;
		@(posedge ref_clk) disable iff (rst)
		scan_tick |=> (din_img & $past(ana_mask)) == 30'h0;
	endproperty
	a_ana_off: assert property (p_ana_off) else $error("analog pin shown as digital");

	property p_res_range;
		@(posedge ref_clk) disable iff (rst)
		res_q[0] <= ipf_pkg::RES_MAX && res_q[7] <= ipf_pkg::RES_MAX;
	endproperty
	a_res_range: assert property (p_res_range) else $error("result above full scale");

	property p_walk;
		@(posedge ref_clk) disable iff (rst || load_q)
		st_q == ipf_pkg::ST_IDLE && scan_tick |=> ##[1:200] st_q == ipf_pkg::ST_IDLE;
	endproperty
	a_walk: assert property (p_walk) else $error("channel walk too long");

	property p_raw_store;
		@(posedge ref_clk) disable iff (rst || load_q)
		st_q == ipf_pkg::ST_UPD && n == 8'h0 |=> quo_q == 18'($past(samp_q[ch_q]));
	endproperty
	a_raw_store: assert property (p_raw_store) else $error("zero count did not pass raw");

	property p_apb;
		@(posedge ref_clk) disable iff (rst)
		acc && !pready |=> pready ##1 !pready;
	endproperty
	a_apb: assert property (p_apb) else $error("apb answer not after one wait");

endmodule // ipf_top

`default_nettype wire

// File: ipf_pkg.sv
// Constants, types and register map of the input pulse and analog filter block.
`default_nettype none

package ipf_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_NS = 4;
	localparam int MS_NS  = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;

	// ****************************************
	// Filter and channel figures
	// ****************************************
	localparam logic [3:0] FLT_DEF_MS = 4'h3;
	localparam logic [3:0] FLT_FIX_MS = 4'h3;
	localparam logic [3:0] FLT_MIN_MS = 4'h3;
	localparam logic [3:0] FLT_GUARD  = 4'h1;
	localparam int N_GRP     = 4;
	localparam int N_CH      = 8;
	localparam int N_PIN     = 30;
	localparam int N_LOW     = 8;
	localparam int SAMP_W    = 12;
	localparam int VAL_W     = 10;
	localparam int SUM_W     = 18;
	localparam int WIN_AW    = 8;
	localparam int DIV_STEPS = 18;
	localparam logic [9:0]  RES_MAX   = 10'h3e8;
	localparam logic [10:0] SCALE_MUL = 11'h3e9;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_FLT    = 8'h00;
	localparam logic [7:0] ADDR_AEN    = 8'h04;
	localparam logic [7:0] ADDR_CNT_LO = 8'h08;
	localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
	localparam logic [7:0] ADDR_LOAD   = 8'h10;
	localparam logic [7:0] ADDR_IMG    = 8'h14;
	localparam logic [7:0] ADDR_RES0   = 8'h20;
	localparam logic [7:0] ADDR_RES7   = 8'h3c;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ipf_apb_req_t;

	typedef struct packed {
		logic [3:0][3:0] flt;
		logic [7:0]      aen;
		logic [7:0][7:0] cnt;
	} ipf_cfg_t;

	localparam ipf_cfg_t CFG_RST = '{flt: {4{FLT_DEF_MS}}, aen: 8'h00, cnt: 64'h0};

	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_UPD, ST_DIV, ST_STORE} ipf_avg_st_t;

endpackage

`default_nettype wire

// File: ipf_field.sv
// Field sensor model driving the raw digital pins and the analog converter codes.
`timescale 1ns/100ps
`default_nettype none

module ipf_field (
	input  wire logic         ref_clk,
	input  wire logic         scan_tick,
	output logic [29:0]       pin_raw,
	output logic [7:0][11:0]  ana_raw
);
	int k;

	function automatic logic [11:0] code_of(input int kk, input int c);
		case ((kk + c) % 3)
			0: return 12'hfff;
			1: return 12'h000;
			default: return 12'h123 + 12'(kk * 37);
		endcase
	endfunction

	initial begin
		k = 0;
		pin_raw = 30'h0;
		for (int c = 0; c < 8; c++) ana_raw[c] = code_of(0, c);
	end

	// Codes move only on a scan edge, so every latched sample is the one held before it.
	always @(posedge ref_clk) begin
		if (scan_tick === 1'b1) begin
			k <= k + 1;
			for (int c = 0; c < 8; c++) ana_raw[c] <= code_of(k + 1, c);
		end
	end

	task automatic pulse(input int p, input int w);
		@(posedge ref_clk);
		pin_raw[p] <= 1'b1;
		repeat (w) @(posedge ref_clk);
		pin_raw[p] <= 1'b0;
	endtask
endmodule // ipf_field

`default_nettype wire

// File: input_pulse_and_analog_filter_bench.sv
// Self-checking bench for the input pulse and analog filter block.
`timescale 1ns/100ps
`default_nettype none

module input_pulse_and_analog_filter_bench;
	// A short millisecond keeps the longest filter setting, 15 ms, to 750 cycles.
	localparam int MS    = 50;
	localparam int SCAN  = 300;
	localparam int LIMIT = 40000;

	logic                  ref_clk;
	logic                  rst;
	logic                  scan_tick;
	logic                  pready;
	logic                  pslverr;
	ipf_pkg::ipf_apb_req_t apb;
	logic [31:0]           prdata;
	logic [29:0]           pin_raw;
	logic [29:0]           din_img;
	logic [7:0][11:0]      ana_raw;
	int                    n_errors;
	int                    n_checks;
	int                    cyc;
	int                    scnt;
	int                    hist [8][$];
	logic [7:0]            cnt [8];
	logic [7:0]            aen;

	ipf_top #(.N_ANA(8), .CYC_PER_MS(MS)) DUT (.ref_clk(ref_clk), .rst(rst), .apb(apb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_raw(pin_raw), .scan_tick(scan_tick), .ana_raw(ana_raw),
		.din_img(din_img));
	ipf_field field (.ref_clk(ref_clk), .scan_tick(scan_tick), .pin_raw(pin_raw), .ana_raw(ana_raw));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ********************
	// Scan, timeout and sample history
	// ********************
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		scnt <= (scnt == SCAN - 1) ? 0 : scnt + 1;
		scan_tick <= (scnt == SCAN - 2);
		if (cyc == LIMIT) begin
			n_errors = n_errors + 1;
			print_verdict();
		end
	end

	always @(posedge ref_clk)
		if (scan_tick === 1'b1)
			for (int c = 0; c < 8; c++) hist[c].push_back((int'(ana_raw[c]) * 1001) >> 12);

	function automatic logic [31:0] avg(input int c);
		int m;
		int s;
		s = 0;
		if (!aen[c]) return 32'h0;
		m = (cnt[c] == 0) ? 1 : ((cnt[c] < hist[c].size()) ? int'(cnt[c]) : hist[c].size());
		if (m == 0) return 32'h0;
		for (int i = 0; i < m; i++) s += hist[c][hist[c].size() - 1 - i];
		return 32'(s / m);
	endfunction

	// ********************
	// Tasks
	// ********************
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		@(posedge ref_clk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge ref_clk);
		apb.penable <= 1'b1;
		// The master waits as long as the slave takes; only the bench timeout ends a hung transfer.
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb <= '0;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		logic [31:0] rd;
		logic        err;
		xfer(1'b0, a, 32'h0, rd, err);
		check({name, " err"}, {31'h0, eerr}, {31'h0, err});
		check(name, exp, rd);
	endtask

	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic eerr);
		logic [31:0] rd;
		logic        err;
		xfer(1'b1, a, d, rd, err);
		check("write err", {31'h0, eerr}, {31'h0, err});
	endtask

	task automatic pulse_chk(input int p, input int w, input logic exp);
		logic seen;
		seen = 1'b0;
		fork
			field.pulse(p, w);
			repeat (w + 2 * SCAN) begin
				@(posedge ref_clk);
				#1;
				if (din_img[p] === 1'b1) seen = 1'b1;
			end
		join
		check($sformatf("din_img[%0d]", p), {31'h0, exp}, {31'h0, seen});
	endtask

	initial begin
		apb = '0;
		rst = 1'b1;
		scan_tick = 1'b0;
		cyc = 0;
		scnt = 0;
		n_errors = 0;
		n_checks = 0;
		aen = 8'h7f;
		cnt = '{8'h00, 8'h01, 8'h04, 8'hff, 8'h02, 8'h08, 8'h03, 8'h02};
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		check("din_img reset", 32'h0, {2'h0, din_img});
		rd_chk("filter reset", ipf_pkg::ADDR_FLT, 32'h00003333, 1'b0);
		rd_chk("enable reset", ipf_pkg::ADDR_AEN, 32'h0, 1'b0);
		rd_chk("result reset", ipf_pkg::ADDR_RES0, 32'h0, 1'b0);
		rd_chk("image reset", ipf_pkg::ADDR_IMG, 32'h0, 1'b0);
		rd_chk("load read", ipf_pkg::ADDR_LOAD, 32'h0, 1'b0);
		rd_chk("unmapped", 8'h44, 32'h0, 1'b1);
		rd_chk("unaligned", 8'h02, 32'h0, 1'b1);
		$display("TEST reset done");
		// Configuration is changed between scans so no averaging walk is cut by the load.
		@(posedge ref_clk iff scan_tick === 1'b1);
		repeat (210) @(posedge ref_clk);
		wr_chk(ipf_pkg::ADDR_AEN, {24'h0, aen}, 1'b0);
		wr_chk(ipf_pkg::ADDR_CNT_LO, {cnt[3], cnt[2], cnt[1], cnt[0]}, 1'b0);
		wr_chk(ipf_pkg::ADDR_CNT_HI, {cnt[7], cnt[6], cnt[5], cnt[4]}, 1'b0);
		wr_chk(ipf_pkg::ADDR_FLT, 32'h000083f0, 1'b0);
		wr_chk(ipf_pkg::ADDR_LOAD, 32'h1, 1'b0);
		for (int c = 0; c < 8; c++) hist[c].delete();
		rd_chk("filter shadow", ipf_pkg::ADDR_FLT, 32'h000083f0, 1'b0);
		rd_chk("counts high", ipf_pkg::ADDR_CNT_HI, {cnt[7], cnt[6], cnt[5], cnt[4]}, 1'b0);
		for (int s = 0; s < 6; s++) begin
			@(posedge ref_clk iff scan_tick === 1'b1);
			repeat (210) @(posedge ref_clk);
			for (int c = 0; c < 8; c++)
				rd_chk($sformatf("result%0d", c), ipf_pkg::ADDR_RES0 + 8'(4 * c), avg(c), 1'b0);
		end
		wr_chk(ipf_pkg::ADDR_RES0 + 8'h04, 32'h155, 1'b0);
		rd_chk("result1 ro", ipf_pkg::ADDR_RES0 + 8'h04, avg(1), 1'b0);
		wr_chk(8'h44, 32'h1, 1'b1);
		$display("TEST analog done");
		pulse_chk(0, SCAN + 10, 1'b1);
		pulse_chk(2, 13 * MS - 1, 1'b0);
		pulse_chk(2, 15 * MS + SCAN + 5, 1'b1);
		pulse_chk(4, MS - 1, 1'b0);
		pulse_chk(4, 3 * MS + SCAN + 5, 1'b1);
		pulse_chk(6, 6 * MS - 1, 1'b0);
		pulse_chk(6, 8 * MS + SCAN + 5, 1'b1);
		pulse_chk(8, MS - 1, 1'b0);
		pulse_chk(8, 3 * MS + SCAN + 5, 1'b1);
		pulse_chk(29, MS - 1, 1'b0);
		pulse_chk(29, 3 * MS + SCAN + 5, 1'b1);
		pulse_chk(22, 3 * MS + SCAN + 5, 1'b0);
		$display("TEST filter done");
		print_verdict();
	end
endmodule // input_pulse_and_analog_filter_bench

`default_nettype wire
